// ==== rtl/asram_consts.svh ====
// Timing and geometry constants for the asynchronous static memory controller.
`ifndef ASRAM_CONSTS_SVH
`define ASRAM_CONSTS_SVH
`define ASRAM_CLK_PERIOD_PS      8000
// Standard grade figures in ns.
`define ASRAM_READ_CYCLE_NS      70
`define ASRAM_ADDR_ACCESS_NS     70
`define ASRAM_OE_TO_DATA_NS      35
`define ASRAM_WE_PULSE_NS        50
`define ASRAM_DATA_SETUP_NS      30
`define ASRAM_WRITE_FLOAT_NS     25
`define ASRAM_OE_FLOAT_NS        25
`define ASRAM_STANDBY_NS         70
`define ASRAM_RETENTION_LEAD_NS  0
// Cycle counts: least times round up.
`define ASRAM_CYC_UP(ns)         (((ns) * 1000 + `ASRAM_CLK_PERIOD_PS - 1) / `ASRAM_CLK_PERIOD_PS)
`define ASRAM_READ_CYC           `ASRAM_CYC_UP(`ASRAM_ADDR_ACCESS_NS + 8)
`define ASRAM_WE_CYC             `ASRAM_CYC_UP(`ASRAM_WRITE_FLOAT_NS + `ASRAM_DATA_SETUP_NS)
`define ASRAM_FLOAT_CYC          `ASRAM_CYC_UP(`ASRAM_OE_FLOAT_NS)
`define ASRAM_STANDBY_CYC        `ASRAM_CYC_UP(`ASRAM_STANDBY_NS)
`define ASRAM_CNT_W              4
`endif

// ==== rtl/asram_pkg.sv ====
// Types for the asynchronous static memory controller.
package asram_pkg;
   typedef enum logic [5:0]
   {
      ASRAM_IDLE    = 6'h01,
      ASRAM_RSETUP  = 6'h02,
      ASRAM_WPULSE  = 6'h04,
      ASRAM_WEND    = 6'h08,
      ASRAM_FLOAT   = 6'h10,
      ASRAM_STANDBY = 6'h20
   } asram_state_t;

   typedef struct packed
   {
      logic        we;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } asram_req_t;

   typedef struct packed
   {
      logic        cs_n;
      logic        we_n;
      logic        oe_n;
      logic [14:0] addr;
      logic [7:0]  dout;
      logic        doe;
   } asram_pins_t;

   typedef struct packed
   {
      asram_state_t state;
      logic [3:0]   cnt;
      asram_pins_t  pins;
      logic         req_ready;
      logic         rvalid;
      logic [7:0]   rdata;
      logic         standby;
      logic [1:0]   din_m;
      logic [15:0]  din_s;
   } asram_regs_t;
endpackage : asram_pkg

// ==== rtl/asram_ctrl.sv ====
// Host controller driving an asynchronous 32K x 8 static memory by its pins.
// =====================================================================
// Behaviour
// - Data setup and hold are timed against the strobe that ends the write.
// - Address must be valid no later than chip select falling.
// - Host must not drive data lines while the memory drives them.
// - Host holds write strobe high during a whole read cycle.
// - Strobe-ended write with output enable low lasts float delay plus setup.
// - Host deselects memory before retention entry; lead time 0 ns.
`timescale 1ns/10ps
`include "asram_consts.svh"

module asram_ctrl
   import asram_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire asram_req_t  req,
   input  wire logic        req_valid,
   output logic             req_ready,
   output logic             rvalid,
   output logic [7:0]       rdata,
   input  wire logic        retention_req,
   output logic             standby,
   output logic             cs_n,
   output logic             we_n,
   output logic             oe_n,
   output logic [14:0]      address_lines,
   output logic [7:0]       data_lines_o,
   output logic             data_lines_oe,
   input  wire logic [7:0]  data_lines_i
);

   localparam logic [3:0] READ_CYC    = 4'(`ASRAM_READ_CYC);
   localparam logic [3:0] WE_CYC      = 4'(`ASRAM_WE_CYC);
   localparam logic [3:0] FLOAT_CYC   = 4'(`ASRAM_FLOAT_CYC);
   localparam logic [3:0] STANDBY_CYC = 4'(`ASRAM_STANDBY_CYC);

   asram_regs_t r_q;
   asram_regs_t r_d;

   // =====================================================================
   // Next state
   always_comb
   begin
      r_d        = r_q;
      r_d.rvalid = 1'b0;
      r_d.din_m  = 2'h0;
      // Data pins come from another domain; two flops before use.
      r_d.din_s  = {r_q.din_s[7:0], data_lines_i};
      case (r_q.state)
         ASRAM_IDLE:
         begin
            r_d.pins.we_n = 1'b1;
            r_d.pins.oe_n = 1'b1;
            r_d.pins.doe  = 1'b0;
            if (retention_req)
            begin
               // Deselect first, standby is reported once the memory is down.
               r_d.pins.cs_n = 1'b1;
               r_d.req_ready = 1'b0;
               r_d.cnt       = STANDBY_CYC;
               r_d.state     = ASRAM_STANDBY;
            end
            else if (req_valid && r_q.req_ready)
            begin
               r_d.req_ready = 1'b0;
               // Address goes out together with chip select falling.
               r_d.pins.addr = req.addr;
               r_d.pins.cs_n = 1'b0;
               if (req.we)
               begin
                  r_d.pins.dout = req.wdata;
                  r_d.pins.doe  = 1'b1;
                  r_d.pins.we_n = 1'b0;
                  r_d.cnt       = WE_CYC;
                  r_d.state     = ASRAM_WPULSE;
               end
               else
               begin
                  r_d.pins.oe_n = 1'b0;
                  r_d.cnt       = READ_CYC;
                  r_d.state     = ASRAM_RSETUP;
               end
            end
            else
            begin
               r_d.pins.cs_n = 1'b1;
               r_d.req_ready = 1'b1;
            end
         end
         ASRAM_RSETUP:
         begin
            // Write strobe stays high for the whole read; host never drives.
            r_d.pins.we_n = 1'b1;
            r_d.pins.doe  = 1'b0;
            if (r_q.cnt == 4'h0)
            begin
               // Two sync stages plus margin cover access time and pin delay.
               r_d.rdata     = r_q.din_s[15:8];
               r_d.rvalid    = 1'b1;
               r_d.pins.oe_n = 1'b1;
               r_d.cnt       = FLOAT_CYC;
               r_d.state     = ASRAM_FLOAT;
            end
            else
            begin
               r_d.cnt = r_q.cnt - 4'h1;
            end
         end
         ASRAM_WPULSE:
         begin
            if (r_q.cnt == 4'h0)
            begin
               // Write strobe rises first, data still held one cycle after.
               r_d.pins.we_n = 1'b1;
               r_d.state     = ASRAM_WEND;
            end
            else
            begin
               r_d.cnt = r_q.cnt - 4'h1;
            end
         end
         ASRAM_WEND:
         begin
            r_d.pins.doe  = 1'b0;
            r_d.pins.cs_n = 1'b1;
            r_d.req_ready = 1'b1;
            r_d.state     = ASRAM_IDLE;
         end
         ASRAM_FLOAT:
         begin
            // Memory may still drive until its float delay passes.
            if (r_q.cnt == 4'h0)
            begin
               r_d.pins.cs_n = 1'b1;
               r_d.req_ready = 1'b1;
               r_d.state     = ASRAM_IDLE;
            end
            else
            begin
               r_d.cnt = r_q.cnt - 4'h1;
            end
         end
         ASRAM_STANDBY:
         begin
            r_d.pins.cs_n = 1'b1;
            r_d.pins.doe  = 1'b0;
            if (r_q.cnt != 4'h0)
            begin
               r_d.cnt = r_q.cnt - 4'h1;
            end
            else if (!retention_req)
            begin
               r_d.standby   = 1'b0;
               r_d.req_ready = 1'b1;
               r_d.state     = ASRAM_IDLE;
            end
            else
            begin
               r_d.standby = 1'b1;
            end
         end
         default:
         begin
            r_d.state = ASRAM_IDLE;
         end
      endcase
   end

   // =====================================================================
   // State register
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         r_q            <= '0;
         r_q.state      <= ASRAM_IDLE;
         r_q.pins.cs_n  <= 1'b1;
         r_q.pins.we_n  <= 1'b1;
         r_q.pins.oe_n  <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign req_ready     = r_q.req_ready;
   assign rvalid        = r_q.rvalid;
   assign rdata         = r_q.rdata;
   assign standby       = r_q.standby;
   assign cs_n          = r_q.pins.cs_n;
   assign we_n          = r_q.pins.we_n;
   assign oe_n          = r_q.pins.oe_n;
   assign address_lines = r_q.pins.addr;
   assign data_lines_o  = r_q.pins.dout;
   assign data_lines_oe = r_q.pins.doe;

endmodule : asram_ctrl

// ==== tb/asram_mem_model.sv ====
// Behavioural model of the 32K x 8 asynchronous static memory.
`timescale 1ns/10ps
module asram_mem_model #(
   parameter int ACC_NS = 30
)
(
   input  wire logic        cs_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic [14:0] addr,
   input  wire logic [7:0]  din,
   output logic [7:0]       dout
);
   // ======================================================================
   // Array and output drivers
   logic [7:0] mem [0:32767];
   logic [7:0] q;
   wire        drive = !cs_n && !oe_n && we_n;
   wire        wr    = !cs_n && !we_n;
   // Capture when the strobe overlap ends; at its start the strobes and the address
   // change in one time step and a level-sensitive write could hit the old address.
   always @(negedge wr) mem[addr] = din;
   always @* if (drive) q = mem[addr];
   // A floating bus shows the inverse of the last byte so a stale value never matches.
   assign #(ACC_NS) dout = drive ? q : ~q;
endmodule : asram_mem_model

// ==== tb/asram_ctrl_monitor.sv ====
// Pin timing checker for the static memory controller.
`timescale 1ns/10ps
module asram_ctrl_monitor
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        req_ready,
   input  wire logic        rvalid,
   input  wire logic        standby,
   input  wire logic        cs_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic [14:0] address_lines,
   input  wire logic [7:0]  data_lines_o,
   input  wire logic        data_lines_oe
);
   // ======================================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   no_contention_a: assert property (data_lines_oe |-> oe_n)
      else $error("host drives bus");
   read_we_high_a: assert property (!oe_n |-> we_n)
      else $error("strobe low in read");
   addr_stable_a: assert property (!cs_n && !$past(cs_n) |-> $stable(address_lines))
      else $error("address moved while selected");
   data_hold_a: assert property
      ($rose(we_n) |-> data_lines_oe && $stable(data_lines_o))
      else $error("write data not held");
   we_width_a: assert property ($fell(we_n) |-> (!we_n)[*7])
      else $error("write pulse short");
   write_sel_a: assert property (!we_n |-> !cs_n && oe_n)
      else $error("strobe outside select");
   read_access_a: assert property
      (rvalid |-> !$past(oe_n, 1) && !$past(oe_n, 9))
      else $error("read sampled early");
   standby_lead_a: assert property (standby |-> cs_n && $past(cs_n, 8))
      else $error("standby too soon");
   idle_pins_a: assert property
      (req_ready |-> cs_n && we_n && oe_n && !data_lines_oe)
      else $error("pins active in idle");
   read_c: cover property (rvalid);
   write_c: cover property ($rose(we_n));
   standby_c: cover property ($rose(standby));
endmodule : asram_ctrl_monitor
bind asram_ctrl asram_ctrl_monitor asram_ctrl_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
   .req_ready(req_ready), .rvalid(rvalid), .standby(standby), .cs_n(cs_n), .we_n(we_n),
   .oe_n(oe_n), .address_lines(address_lines), .data_lines_o(data_lines_o),
   .data_lines_oe(data_lines_oe));

// ==== tb/testbench.sv ====
// Self-checking bench for the static memory controller.
`timescale 1ns/10ps
module testbench;
   import asram_pkg::*;
   // ======================================================================
   // Clock, reset and wiring
   logic clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0, retention_req = 1'b0;
   logic req_ready, rvalid, standby, cs_n, we_n, oe_n, data_lines_oe;
   logic [14:0] address_lines;
   logic [7:0] rdata, data_lines_o, mem_q, data_lines_i;
   asram_req_t req = '0;
   int mismatches = 0, num_checks = 0;
   always #4 clk_sys = ~clk_sys;
   assign data_lines_i = data_lines_oe ? data_lines_o : mem_q;
   asram_ctrl asram_ctrl_i (.clk_sys(clk_sys), .resetn(resetn), .req(req),
      .req_valid(req_valid), .req_ready(req_ready), .rvalid(rvalid), .rdata(rdata),
      .retention_req(retention_req), .standby(standby), .cs_n(cs_n), .we_n(we_n),
      .oe_n(oe_n), .address_lines(address_lines), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i));
   // Worst standard-grade access leaves the controller only its sampling margin.
   asram_mem_model #(.ACC_NS(70)) asram_mem_model_i (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
      .addr(address_lines), .din(data_lines_i), .dout(mem_q));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      logic took;
      n = 0;
      took = 1'b0;
      req = '{we: w, addr: a, wdata: d};
      req_valid = 1'b1;
      // Ready is looked at off the edge, so the next edge is the one that takes the request.
      while (!took && n < 60)
      begin
         took = (req_ready === 1'b1);
         @(posedge clk_sys);
         #1 n++;
      end
      req_valid = 1'b0;
      if (!took)
         mismatches++;
      // One edge passes with valid low before any following request.
      @(posedge clk_sys);
      #1;
   endtask : xfer
   task automatic read_chk(input logic [14:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      xfer(1'b0, a, 8'h00);
      while (rvalid !== 1'b1 && n < 40)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      check({7'h00, rvalid}, 8'h01);
      check(rdata, exp);
   endtask : read_chk
   // ======================================================================
   // Scenarios
   task automatic t_write_read();
      xfer(1'b1, 15'h0000, 8'hA5);
      xfer(1'b1, 15'h7FFF, 8'h3C);
      xfer(1'b1, 15'h0000, 8'h5A);
      read_chk(15'h7FFF, 8'h3C);
      read_chk(15'h0000, 8'h5A);
   endtask : t_write_read
   task automatic t_standby();
      int n;
      n = 0;
      @(posedge clk_sys);
      #1 retention_req = 1'b1;
      while (standby !== 1'b1 && n < 30)
      begin
         @(posedge clk_sys);
         #1 n++;
      end
      check({5'h00, standby, cs_n, req_ready}, 8'h06);
      retention_req = 1'b0;
      read_chk(15'h7FFF, 8'h3C);
   endtask : t_standby
   initial
   begin
      repeat (16) @(posedge clk_sys);
      #1 resetn = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 t_write_read();
      t_standby();
      test_done();
   end
   initial
   begin
      #100000;
      mismatches++;
      test_done();
   end
endmodule : testbench
